/* design/qed_pkg.sv */
package qed_pkg;

    // ----------------------------------------------------------------
    // register map (byte addresses, one aligned word each)
    // ----------------------------------------------------------------
    localparam logic [7:0] QED_OFF_CTRL = 8'h00;    // decoder_control_register
    localparam logic [7:0] QED_OFF_UPPER = 8'h04;   // counter_upper_limit
    localparam logic [7:0] QED_OFF_LOWER = 8'h08;   // counter_lower_limit
    localparam logic [7:0] QED_OFF_FILT = 8'h0C;    // phase_filter_value a/b
    localparam logic [7:0] QED_OFF_COUNT = 8'h10;   // position count, read only

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int QED_CTRL_ENABLE_BIT = 0;         // phase_encoding_select
    localparam int QED_CTRL_DIR_BIT = 1;            // count_direction_flag
    localparam int QED_FILT_B_LSB = 8;              // b filter value position

    // ----------------------------------------------------------------
    // widths and reset values
    // ----------------------------------------------------------------
    localparam int QED_CNT_W = 16;                  // signed position width
    localparam int QED_FILT_W = 4;                  // filter value width
    localparam logic [15:0] QED_UPPER_RST = 16'h07FF;   // 2047
    localparam logic [15:0] QED_LOWER_RST = 16'hF800;   // -2048
    localparam logic [3:0] QED_FILT_RST = 4'h3;         // 3
    localparam logic [1:0] QED_RESP_OKAY = 2'h0;
    localparam logic [1:0] QED_RESP_SLVERR = 2'h2;

    // filter output plus edge information for one phase
    typedef struct packed {
        logic level;     // filtered level
        logic edge_seen; // one-cycle pulse on any filtered edge
    } qed_phase_t;

endpackage : qed_pkg

/* design/qed_decoder.sv */
// Functional notes
// - count direction from relative phase of inputs
// - count every edge of both phases
// - b lags a: increment per edge
// - b leads a: decrement per edge
// - readable direction flag in control register
// - programmable upper limit, default 2047
// - signed negative lower limit, default -2048
// - per-phase glitch filter, programmable, default 3
// - index output unused, two phases only
//
// Decided for this implementation: the address map and the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none

module qed_decoder
    import qed_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic phase_a_i,
    input wire logic phase_b_i,
    // axi4-lite slave
    input wire logic [7:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [7:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    output logic [QED_CNT_W-1:0] position_o,
    output logic count_direction_flag_o
);

    // ----------------------------------------------------------------
    // input synchroniser and glitch filter, one per phase
    // ----------------------------------------------------------------
    logic [1:0] phase_raw;              // raw pins, index a=0 b=1
    logic [1:0] sync_meta;              // first stage, read only by second
    logic [1:0] sync_q;                 // synchronised levels
    logic [QED_FILT_W-1:0] filt_cnt [2];    // stable-run counters
    logic [QED_FILT_W-1:0] next_filt_cnt [2];
    logic [1:0] filt_lvl;               // filtered levels
    logic [1:0] next_filt_lvl;
    logic [QED_FILT_W-1:0] filt_val [2];    // programmed filter values
    qed_phase_t phase_info [2];

    assign phase_raw = {phase_b_i, phase_a_i};

    // two-flop synchroniser ahead of the filter
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            sync_meta <= 2'h0;
            sync_q <= 2'h0;
        end
        else
        begin
            sync_meta <= phase_raw;
            sync_q <= sync_meta;
        end
    end

    generate
        for (genvar g = 0; g < 2; g++)
        begin : g_filt
            // a new level is accepted only after it holds filt_val+1 cycles,
            // so shorter pulses vanish; costs that much latency per edge
            always_comb
            begin
                next_filt_cnt[g] = '0;
                next_filt_lvl[g] = filt_lvl[g];
                if (sync_q[g] != filt_lvl[g])
                begin
                    // candidate level differs from the accepted one
                    if (filt_cnt[g] >= filt_val[g])
                    begin
                        next_filt_lvl[g] = sync_q[g];
                    end
                    else
                    begin
                        next_filt_cnt[g] = filt_cnt[g] + 1'b1;
                    end
                end
            end

            always_ff @(posedge clk_i or negedge reset_n_i)
            begin
                if (!reset_n_i)
                begin
                    filt_cnt[g] <= '0;
                    filt_lvl[g] <= 1'b0;
                end
                else
                begin
                    filt_cnt[g] <= next_filt_cnt[g];
                    filt_lvl[g] <= next_filt_lvl[g];
                end
            end

            assign phase_info[g].level = filt_lvl[g];
            assign phase_info[g].edge_seen = next_filt_lvl[g] != filt_lvl[g];
        end
    endgenerate

    // ----------------------------------------------------------------
    // quadrature counter
    // ----------------------------------------------------------------
    logic enable;                       // phase_encoding_select
    logic signed [QED_CNT_W-1:0] upper_limit;
    logic signed [QED_CNT_W-1:0] lower_limit;
    logic signed [QED_CNT_W-1:0] count;
    logic signed [QED_CNT_W-1:0] next_count;
    logic direction;                    // 1 = up
    logic next_direction;
    logic step_up;
    logic step_any;

    // direction from the new state against the old: x4 decoding.
    // up when (new a xor old b) -- b lags a. a simultaneous double
    // edge is illegal gray and is dropped.
    always_comb
    begin
        step_any = phase_info[0].edge_seen ^ phase_info[1].edge_seen;
        step_up = next_filt_lvl[0] ^ phase_info[1].level;
        next_count = count;
        next_direction = direction;
        if (enable && step_any)
        begin
            next_direction = step_up;
            if (step_up)
            begin
                // increment, wrap to lower past upper; the step is sized to the
                // count, since a one-bit signed one would read as minus one
                next_count = (count >= upper_limit) ? lower_limit
                                                    : count + 16'sh0001;
            end
            else
            begin
                // decrement, wrap to upper past lower
                next_count = (count <= lower_limit) ? upper_limit
                                                    : count - 16'sh0001;
            end
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            count <= '0;
            direction <= 1'b1;
        end
        else
        begin
            count <= next_count;
            direction <= next_direction;
        end
    end

    assign position_o = count;
    assign count_direction_flag_o = direction;

    // ----------------------------------------------------------------
    // axi4-lite slave: write and read, one outstanding each
    // ----------------------------------------------------------------
    logic aw_held, next_aw_held;        // write address captured
    logic w_held, next_w_held;          // write data captured
    logic [7:0] aw_addr, next_aw_addr;
    logic [31:0] w_data, next_w_data;
    logic [3:0] w_strb, next_w_strb;
    logic bvalid, next_bvalid;
    logic [1:0] bresp, next_bresp;
    logic rvalid, next_rvalid;
    logic [31:0] rdata, next_rdata;
    logic [1:0] rresp, next_rresp;
    logic next_enable;
    logic signed [QED_CNT_W-1:0] next_upper, next_lower;
    logic [QED_FILT_W-1:0] next_fval [2];

    // byte-lane merge of a 16-bit field
    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] d,
                                            input logic [3:0] s);
        merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction : merge16

    assign s_axi_awready_o = !aw_held && !bvalid;
    assign s_axi_wready_o = !w_held && !bvalid;
    assign s_axi_arready_o = !rvalid;

    always_comb
    begin
        next_aw_held = aw_held;
        next_w_held = w_held;
        next_aw_addr = aw_addr;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_bvalid = bvalid;
        next_bresp = bresp;
        next_rvalid = rvalid;
        next_rdata = rdata;
        next_rresp = rresp;
        next_enable = enable;
        next_upper = upper_limit;
        next_lower = lower_limit;
        next_fval[0] = filt_val[0];
        next_fval[1] = filt_val[1];
        // address and data may arrive in either order
        if (s_axi_awvalid_i && s_axi_awready_o)
        begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr_i;
        end
        if (s_axi_wvalid_i && s_axi_wready_o)
        begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata_i;
            next_w_strb = s_axi_wstrb_i;
        end
        // both held: perform the write and answer
        if (aw_held && w_held)
        begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = QED_RESP_OKAY;
            unique case (aw_addr)
                QED_OFF_CTRL:
                begin
                    if (w_strb[0])
                    begin
                        next_enable = w_data[QED_CTRL_ENABLE_BIT];
                    end
                end
                QED_OFF_UPPER: next_upper = merge16(upper_limit, w_data, w_strb);
                QED_OFF_LOWER: next_lower = merge16(lower_limit, w_data, w_strb);
                QED_OFF_FILT:
                begin
                    if (w_strb[0])
                    begin
                        next_fval[0] = w_data[QED_FILT_W-1:0];
                    end
                    if (w_strb[1])
                    begin
                        next_fval[1] = w_data[QED_FILT_B_LSB +: QED_FILT_W];
                    end
                end
                QED_OFF_COUNT: next_bresp = QED_RESP_OKAY;  // read only, write ignored
                default: next_bresp = QED_RESP_SLVERR;      // unmapped
            endcase
        end
        if (bvalid && s_axi_bready_i)
        begin
            next_bvalid = 1'b0;
        end
        // read: answer the cycle after the address is taken
        if (s_axi_arvalid_i && s_axi_arready_o)
        begin
            next_rvalid = 1'b1;
            next_rresp = QED_RESP_OKAY;
            next_rdata = 32'h0000_0000;
            unique case (s_axi_araddr_i)
                QED_OFF_CTRL:
                begin
                    next_rdata[QED_CTRL_ENABLE_BIT] = enable;
                    next_rdata[QED_CTRL_DIR_BIT] = direction;
                end
                QED_OFF_UPPER: next_rdata = {{16{upper_limit[15]}}, upper_limit};
                QED_OFF_LOWER: next_rdata = {{16{lower_limit[15]}}, lower_limit};
                QED_OFF_FILT:
                begin
                    next_rdata[QED_FILT_W-1:0] = filt_val[0];
                    next_rdata[QED_FILT_B_LSB +: QED_FILT_W] = filt_val[1];
                end
                QED_OFF_COUNT: next_rdata = {{16{count[15]}}, count};
                default: next_rresp = QED_RESP_SLVERR;
            endcase
        end
        else if (rvalid && s_axi_rready_i)
        begin
            next_rvalid = 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            bvalid <= 1'b0;
            bresp <= 2'h0;
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= 2'h0;
            enable <= 1'b1;
            upper_limit <= QED_UPPER_RST;
            lower_limit <= QED_LOWER_RST;
            filt_val[0] <= QED_FILT_RST;
            filt_val[1] <= QED_FILT_RST;
        end
        else
        begin
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            aw_addr <= next_aw_addr;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            bvalid <= next_bvalid;
            bresp <= next_bresp;
            rvalid <= next_rvalid;
            rdata <= next_rdata;
            rresp <= next_rresp;
            enable <= next_enable;
            upper_limit <= next_upper;
            lower_limit <= next_lower;
            filt_val[0] <= next_fval[0];
            filt_val[1] <= next_fval[1];
        end
    end

    assign s_axi_bvalid_o = bvalid;
    assign s_axi_bresp_o = bresp;
    assign s_axi_rvalid_o = rvalid;
    assign s_axi_rdata_o = rdata;
    assign s_axi_rresp_o = rresp;

endmodule : qed_decoder

`default_nettype wire

/* test/qed_decoder_checker.sv */
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------
// bus handshakes and position stepping seen from the ports
// ----------------------------------------------------------------
module qed_decoder_checker
    import qed_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic phase_a_i,
    input wire logic phase_b_i,
    input wire logic s_axi_awvalid_i,
    input wire logic s_axi_awready_o,
    input wire logic s_axi_wvalid_i,
    input wire logic s_axi_wready_o,
    input wire logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic s_axi_arvalid_i,
    input wire logic s_axi_arready_o,
    input wire logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    input wire logic [31:0] s_axi_rdata_o,
    input wire logic [QED_CNT_W-1:0] position_o,
    input wire logic count_direction_flag_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    logic [4:0] quiet_cnt; // cycles since a phase pin last moved
    logic [4:0] next_quiet_cnt;
    logic [1:0] pins_q; // pin levels one cycle back
    // ----------------------------------------------------------------
    // quiet counter: saturates, since only long silences matter
    // ----------------------------------------------------------------
    always_comb
    begin
        next_quiet_cnt = (quiet_cnt == 5'h1F) ? quiet_cnt : quiet_cnt + 5'h01;
        if ({phase_a_i, phase_b_i} != pins_q)
            next_quiet_cnt = 5'h00;
    end
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            quiet_cnt <= 5'h00;
            pins_q <= 2'h0;
        end
        else
        begin
            quiet_cnt <= next_quiet_cnt;
            pins_q <= {phase_a_i, phase_b_i};
        end
    end
    wr_resp_a: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i
        && s_axi_wready_o |=> ##[0:1] s_axi_bvalid_o) else $error("write answer missing");
    bvalid_hold_a: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o)
        else $error("write answer dropped");
    rd_resp_a: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
        else $error("read answer late");
    rdata_hold_a: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o
        && $stable(s_axi_rdata_o)) else $error("read data not held");
    step_size_a: assert property ($changed(position_o) |->
        (position_o - $past(position_o)) inside {16'h0001, 16'hFFFF}
        || position_o[15] != $past(position_o[15])) else $error("position jumped");
    dir_up_a: assert property (position_o == $past(position_o) + 16'h0001 |->
        count_direction_flag_o) else $error("up step without up flag");
    dir_down_a: assert property (position_o == $past(position_o) - 16'h0001 |->
        !count_direction_flag_o) else $error("down step without down flag");
    quiet_hold_a: assert property (quiet_cnt > 5'h18 |-> $stable(position_o))
        else $error("count moved with pins quiet");
    wrap_c: cover property (count_direction_flag_o && position_o[15] && !$past(position_o[15]));
    down_c: cover property ($fell(count_direction_flag_o));
    read_c: cover property (s_axi_rvalid_o && s_axi_rready_i);
endmodule : qed_decoder_checker
bind qed_decoder qed_decoder_checker chk_u (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .phase_a_i(phase_a_i), .phase_b_i(phase_b_i), .s_axi_awvalid_i(s_axi_awvalid_i),
    .s_axi_awready_o(s_axi_awready_o), .s_axi_wvalid_i(s_axi_wvalid_i),
    .s_axi_wready_o(s_axi_wready_o), .s_axi_bvalid_o(s_axi_bvalid_o),
    .s_axi_bready_i(s_axi_bready_i), .s_axi_arvalid_i(s_axi_arvalid_i),
    .s_axi_arready_o(s_axi_arready_o), .s_axi_rvalid_o(s_axi_rvalid_o),
    .s_axi_rready_i(s_axi_rready_i), .s_axi_rdata_o(s_axi_rdata_o),
    .position_o(position_o), .count_direction_flag_o(count_direction_flag_o));
`default_nettype wire

/* test/qed_encoder_model.sv */
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------
// incremental encoder: two quadrature phases, index left out
// ----------------------------------------------------------------
module qed_encoder_model
(
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic step_i, // one pulse turns the shaft by one edge
    input wire logic fwd_i, // 1: phase b lags phase a
    input wire logic glitch_i, // false pulse laid over phase a
    output logic phase_a_o,
    output logic phase_b_o
);
    logic [1:0] angle; // quarter-period index of the shaft
    logic [1:0] next_angle;
    // ----------------------------------------------------------------
    // shaft position
    // ----------------------------------------------------------------
    always_comb
    begin
        next_angle = angle;
        if (step_i)
            next_angle = fwd_i ? angle + 2'h1 : angle - 2'h1;
    end
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            angle <= 2'h0;
        else
            angle <= next_angle;
    end
    // gray order 00,10,11,01: one phase moves per step, so no edge pairs collide
    assign phase_a_o = angle[1] ^ angle[0] ^ glitch_i;
    assign phase_b_o = angle[1];
endmodule : qed_encoder_model
`default_nettype wire

/* test/test_quadrature_encoder_decoder.sv */
`timescale 1ns/100ps
`default_nettype none
module test_quadrature_encoder_decoder;
    import qed_pkg::*;
    logic clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic step = 1'b0, fwd = 1'b0, glitch = 1'b0, phase_a, phase_b;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0, rdata;
    logic awready, wready, bvalid, arready, rvalid, dir_flag, enabled = 1'b1;
    logic [1:0] bresp, rresp, gidx = 2'h0;
    logic [15:0] position, last_pos = 16'h0, exp_pos = 16'h0;
    logic [15:0] upper = QED_UPPER_RST, lower = QED_LOWER_RST;
    logic [33:0] rd_q[$]; // expected {resp, data} of reads
    logic [16:0] pos_q[$]; // expected {direction, position}
    logic [31:0] seed = 32'h0000003E;
    int error_cnt = 0, n_compared = 0, cycles = 0;
    always #2.5 clk_i = ~clk_i;
    qed_decoder dut_u (.clk_i(clk_i), .reset_n_i(reset_n_i), .phase_a_i(phase_a),
        .phase_b_i(phase_b), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
        .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF),
        .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
        .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready), .s_axi_araddr_i(araddr),
        .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
        .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
        .position_o(position), .count_direction_flag_o(dir_flag));
    qed_encoder_model enc_u (.clk_i(clk_i), .reset_n_i(reset_n_i), .step_i(step),
        .fwd_i(fwd), .glitch_i(glitch), .phase_a_o(phase_a), .phase_b_o(phase_b));
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs
    task automatic note(input logic ok, input string what);
        n_compared++;
        if (!ok)
            error_cnt++;
        if (!ok)
            $display("MISMATCH at %0t: %s", $time, what);
    endtask : note
    task automatic cmp_rd(input logic [33:0] got);
        note(rd_q.size() > 0 && got === rd_q.pop_front(), "register read");
    endtask : cmp_rd
    task automatic cmp_pos(input logic [16:0] got);
        note(pos_q.size() > 0 && got === pos_q.pop_front(), "position or direction");
    endtask : cmp_pos
    // ----------------------------------------------------------------
    // monitor: settled outputs looked at on the falling edge
    // ----------------------------------------------------------------
    always @(negedge clk_i)
    begin
        if (reset_n_i && rvalid && rready)
            cmp_rd({rresp, rdata});
        if (reset_n_i && position !== last_pos)
            cmp_pos({dir_flag, position});
        last_pos = position;
    end
    task automatic push_exp(input logic d);
        exp_pos = d ? ((exp_pos == upper) ? lower : exp_pos + 16'h1)
                    : ((exp_pos == lower) ? upper : exp_pos - 16'h1);
        pos_q.push_back({d, exp_pos});
    endtask : push_exp
    task automatic enc_step(input logic d, input int hold);
        @(posedge clk_i);
        step <= 1'b1;
        fwd <= d;
        @(posedge clk_i);
        step <= 1'b0;
        gidx = d ? gidx + 2'h1 : gidx - 2'h1;
        if (enabled)
            push_exp(d);
        repeat (hold) @(posedge clk_i);
    endtask : enc_step
    // a two-cycle false pulse on phase a; its first edge counts up from even places, down from odd ones
    task automatic glitch_a(input logic accept);
        @(posedge clk_i);
        glitch <= 1'b1;
        if (accept)
            push_exp(!gidx[0]);
        if (accept)
            push_exp(gidx[0]);
        repeat (2) @(posedge clk_i);
        glitch <= 1'b0;
        repeat (14) @(posedge clk_i);
    endtask : glitch_a
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge clk_i);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw_ok && w_ok))
        begin
            @(posedge clk_i);
            aw_ok = aw_ok | (awvalid & awready);
            w_ok = w_ok | (wvalid & wready);
            awvalid <= awvalid & ~awready;
            wvalid <= wvalid & ~wready;
        end
        do @(posedge clk_i); while (bvalid !== 1'b1);
        bready <= 1'b0;
        note(bresp === er, "write response");
    endtask : axi_wr
    task automatic axi_rd(input logic [7:0] a, input logic [33:0] e);
        rd_q.push_back(e);
        @(posedge clk_i);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge clk_i); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge clk_i); while (rvalid !== 1'b1);
        rready <= 1'b0;
    endtask : axi_rd
    task automatic rd_count();
        axi_rd(QED_OFF_COUNT, {QED_RESP_OKAY, {16{exp_pos[15]}}, exp_pos});
    endtask : rd_count
    task automatic complete_run();
        $display("compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : complete_run
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 20000)
            error_cnt++;
        if (cycles == 20000)
            complete_run();
    end
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial
    begin
        repeat (20) @(posedge clk_i);
        reset_n_i <= 1'b1;
        axi_rd(QED_OFF_CTRL, {QED_RESP_OKAY, 32'h00000003});
        axi_rd(QED_OFF_UPPER, {QED_RESP_OKAY, 32'h000007FF});
        axi_rd(QED_OFF_LOWER, {QED_RESP_OKAY, 32'hFFFFF800});
        axi_rd(QED_OFF_FILT, {QED_RESP_OKAY, 32'h00000303});
        axi_rd(8'h20, {QED_RESP_SLVERR, 32'h00000000});
        axi_wr(8'h20, 32'h0000FFFF, QED_RESP_SLVERR);
        $display("test reset values done");
        repeat (5) enc_step(1'b1, 12);
        repeat (3) enc_step(1'b0, 12);
        axi_rd(QED_OFF_CTRL, {QED_RESP_OKAY, 32'h00000001});
        rd_count();
        $display("test counting done");
        axi_wr(QED_OFF_UPPER, 32'h00000003, QED_RESP_OKAY);
        upper = 16'h0003;
        axi_wr(QED_OFF_LOWER, 32'h0000FFFC, QED_RESP_OKAY);
        lower = 16'hFFFC;
        axi_rd(QED_OFF_LOWER, {QED_RESP_OKAY, 32'hFFFFFFFC});
        repeat (2) enc_step(1'b1, 12);
        enc_step(1'b0, 12);
        $display("test wrap done");
        glitch_a(1'b0);
        axi_wr(QED_OFF_FILT, 32'h00000000, QED_RESP_OKAY);
        glitch_a(1'b1);
        axi_wr(QED_OFF_FILT, 32'h00000303, QED_RESP_OKAY);
        $display("test filter done");
        axi_wr(QED_OFF_CTRL, 32'h00000000, QED_RESP_OKAY);
        enabled = 1'b0;
        enc_step(1'b1, 12);
        rd_count();
        axi_wr(QED_OFF_CTRL, 32'h00000001, QED_RESP_OKAY);
        enabled = 1'b1;
        $display("test enable done");
        repeat (8)
        begin
            seed = xs(seed);
            enc_step(seed[0], 10 + int'(seed[3:1]));
        end
        rd_count();
        repeat (20) @(posedge clk_i);
        note(pos_q.size() == 0 && rd_q.size() == 0, "results left over");
        $display("test random steps done");
        complete_run();
    end
endmodule : test_quadrature_encoder_decoder
`default_nettype wire
